// file: tsmf_pkg.sv
// constants shared by the temperature sensor mode and format block
package tsmf_pkg;
  // register addresses
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CFG    = 8'h01;
  localparam logic [7:0] ADDR_TEMP   = 8'h02;
  localparam logic [7:0] ADDR_ID     = 8'h03;
  localparam logic [7:0] ADDR_CRIT   = 8'h04;
  localparam logic [7:0] ADDR_HYST   = 8'h05;
  localparam logic [7:0] ADDR_HIGH   = 8'h06;
  localparam logic [7:0] ADDR_LOW    = 8'h07;
  // configuration field positions
  localparam int CFG_FQ_LSB  = 0;
  localparam int CFG_CRIT_POL = 2;
  localparam int CFG_LIM_POL = 3;
  localparam int CFG_IRQ     = 4;
  localparam int CFG_OP_LSB  = 5;
  localparam int CFG_RES16   = 7;
  // status field positions
  localparam int ST_LOW_BIT  = 4;
  localparam int ST_HIGH_BIT = 5;
  localparam int ST_CRIT_BIT = 6;
  localparam int ST_RDY_BIT  = 7;
  // operation modes
  localparam logic [1:0] OP_CONT    = 2'h0;
  localparam logic [1:0] OP_ONESHOT = 2'h1;
  localparam logic [1:0] OP_SPS     = 2'h2;
  localparam logic [1:0] OP_SHUT    = 2'h3;
  // values after reset
  localparam logic [7:0]  CFG_RST  = 8'h00;
  localparam logic [15:0] TEMP_RST = 16'h0000;
  localparam logic [15:0] CRIT_RST = 16'h4980;
  localparam logic [7:0]  HYST_RST = 8'h05;
  localparam logic [15:0] HIGH_RST = 16'h2000;
  localparam logic [15:0] LOW_RST  = 16'h0500;
  // timing
  localparam int unsigned CLK_HZ      = 100_000_000;
  localparam int unsigned CYC_PER_MS  = CLK_HZ / 1000;
  localparam int unsigned CONV_MS     = 240;
  localparam int unsigned SPS_CONV_MS = 60;
  localparam int unsigned SPS_IDLE_MS = 940;
  localparam int unsigned WAKE_MS     = 1;
  localparam int unsigned CONV_CYC     = CYC_PER_MS * CONV_MS;
  localparam int unsigned SPS_CONV_CYC = CYC_PER_MS * SPS_CONV_MS;
  localparam int unsigned SPS_IDLE_CYC = CYC_PER_MS * SPS_IDLE_MS;
  localparam int unsigned WAKE_CYC     = CYC_PER_MS * WAKE_MS;
  localparam logic [2:0] FCNT_MAX = 3'h4;
  // sequencer states
  typedef enum logic [1:0] {ST_WAKE, ST_CONV, ST_IDLE, ST_SHUT} tsmf_state_e;
endpackage

// file: tsmf_timer.sv
// down-counting interval timer with a done pulse
`timescale 1ns/10ps
module tsmf_timer #(
  parameter int W = 32
) (
  input  wire logic         core_clk,
  input  wire logic         reset_n,
  input  wire logic         start,
  input  wire logic [W-1:0] load,
  output logic              busy,
  output logic              done
);
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  logic         done_ff;
  logic         nxt_done;

  // reload on start, otherwise count down and pulse at one
  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_done = 1'b0;
    if (start) begin
      nxt_cnt = load;
    end else if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - W'(1);
      nxt_done = (cnt_ff == W'(1));
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff  <= '0;
      done_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

  assign busy = (cnt_ff != '0);
  assign done = done_ff;
endmodule

// file: tsmf_top.sv
// mode sequencer, fault queue, alarms and result formatting
`timescale 1ns/10ps
module tsmf_top #(
  parameter int unsigned CONV_CYC     = tsmf_pkg::CONV_CYC,
  parameter int unsigned SPS_CONV_CYC = tsmf_pkg::SPS_CONV_CYC,
  parameter int unsigned SPS_IDLE_CYC = tsmf_pkg::SPS_IDLE_CYC,
  parameter int unsigned WAKE_CYC     = tsmf_pkg::WAKE_CYC,
  parameter logic [7:0]  ID_VALUE     = 8'h5a  // arbitrary identity value
) (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic [15:0] adc_code,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  output logic             critical_alarm_out,
  output logic             critical_alarm_out_oe,
  output logic             limit_alarm_out,
  output logic             limit_alarm_out_oe
);
  logic [15:0] adc_meta_ff;
  logic [15:0] adc_sync_ff;
  tsmf_pkg::tsmf_state_e state_ff;
  tsmf_pkg::tsmf_state_e nxt_state;
  logic        boot_ff;
  logic        tmr_start;
  logic [31:0] tmr_load;
  logic        tmr_busy;
  logic        tmr_done;
  logic [7:0]  cfg_ff;
  logic [7:0]  nxt_cfg;
  logic [15:0] temp_ff;
  logic [15:0] nxt_temp;
  logic [15:0] critical_limit_ff;
  logic [15:0] nxt_critical_limit;
  logic [7:0]  hysteresis_value_ff;
  logic [7:0]  nxt_hysteresis_value;
  logic [15:0] upper_limit_ff;
  logic [15:0] nxt_upper_limit;
  logic [15:0] lower_limit_ff;
  logic [15:0] nxt_lower_limit;
  logic        flag_crit_ff;
  logic        nxt_flag_crit;
  logic        flag_high_ff;
  logic        nxt_flag_high;
  logic        flag_low_ff;
  logic        nxt_flag_low;
  logic        rdy_n_ff;
  logic        nxt_rdy_n;
  logic [2:0]  fcnt_ff;
  logic [2:0]  nxt_fcnt;
  logic        crit_al_ff;
  logic        nxt_crit_al;
  logic        lim_al_ff;
  logic        nxt_lim_al;
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;
  logic        mode_wr;
  logic [1:0]  new_op;
  logic [1:0]  op;
  logic        irq_mode;
  logic        conv_done;
  logic [15:0] cmp_src;
  logic signed [14:0] t_s;
  logic signed [14:0] crit_s;
  logic signed [14:0] high_s;
  logic signed [14:0] low_s;
  logic signed [14:0] hy_s;
  logic        crit_hit;
  logic        high_hit;
  logic        low_hit;
  logic        fault;
  logic        qualified;
  logic        below_crit;
  logic        within_lim;

  // two-stage synchroniser for the converter word
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      adc_meta_ff <= 16'h0000;
      adc_sync_ff <= 16'h0000;
    end else begin
      adc_meta_ff <= adc_code;
      adc_sync_ff <= adc_meta_ff;
    end
  end

  assign op       = cfg_ff[tsmf_pkg::CFG_OP_LSB +: 2];
  assign new_op   = reg_wdata[tsmf_pkg::CFG_OP_LSB +: 2];
  assign irq_mode = cfg_ff[tsmf_pkg::CFG_IRQ];
  assign mode_wr  = reg_wr && (reg_addr == tsmf_pkg::ADDR_CFG);
  assign conv_done = tmr_done && (state_ff == tsmf_pkg::ST_CONV) && !mode_wr;

  // limit comparison in 13-bit units, on the new sample or the held result
  assign cmp_src    = conv_done ? adc_sync_ff : temp_ff;
  assign t_s        = 15'($signed(cmp_src[15:3]));
  assign crit_s     = 15'($signed(critical_limit_ff[15:3]));
  assign high_s     = 15'($signed(upper_limit_ff[15:3]));
  assign low_s      = 15'($signed(lower_limit_ff[15:3]));
  assign hy_s       = $signed({3'h0, hysteresis_value_ff, 4'h0}); // whole degrees to lsb
  assign crit_hit   = t_s > crit_s;
  assign high_hit   = t_s > high_s;
  assign low_hit    = t_s < low_s;
  assign fault      = crit_hit || high_hit || low_hit;
  assign qualified  = fault && (fcnt_ff >= {1'b0, cfg_ff[tsmf_pkg::CFG_FQ_LSB +: 2]});
  assign below_crit = t_s < (crit_s - hy_s);
  assign within_lim = (t_s < (high_s - hy_s)) && (t_s > (low_s + hy_s));

  // conversion timer
  tsmf_timer #(
    .W (32)
  ) u_timer (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .start    (tmr_start),
    .load     (tmr_load),
    .busy     (tmr_busy),
    .done     (tmr_done)
  );

  // operation-mode sequencer
  always_comb begin
    nxt_state = state_ff;
    tmr_start = 1'b0;
    tmr_load  = 32'(CONV_CYC);
    if (mode_wr) begin
      if (new_op == tsmf_pkg::OP_SHUT) begin
        nxt_state = tsmf_pkg::ST_SHUT;
      end else if (state_ff == tsmf_pkg::ST_SHUT) begin
        nxt_state = tsmf_pkg::ST_WAKE;
        tmr_start = 1'b1;
        tmr_load  = 32'(WAKE_CYC);
      end else begin
        nxt_state = tsmf_pkg::ST_CONV;
        tmr_start = 1'b1;
        tmr_load  = (new_op == tsmf_pkg::OP_SPS) ? 32'(SPS_CONV_CYC) : 32'(CONV_CYC);
      end
    end else if (boot_ff) begin                                  // a mode write wins over boot
      tmr_start = 1'b1;
    end else if (tmr_done) begin
      unique case (state_ff)
        tsmf_pkg::ST_WAKE: begin
          nxt_state = tsmf_pkg::ST_CONV;
          tmr_start = 1'b1;
          tmr_load  = (op == tsmf_pkg::OP_SPS) ? 32'(SPS_CONV_CYC) : 32'(CONV_CYC);
        end
        tsmf_pkg::ST_CONV: begin
          if (op == tsmf_pkg::OP_ONESHOT) begin
            nxt_state = tsmf_pkg::ST_SHUT;
          end else if (op == tsmf_pkg::OP_SPS) begin
            nxt_state = tsmf_pkg::ST_IDLE;
            tmr_start = 1'b1;
            tmr_load  = 32'(SPS_IDLE_CYC);
          end else begin
            tmr_start = 1'b1;
          end
        end
        tsmf_pkg::ST_IDLE: begin
          nxt_state = tsmf_pkg::ST_CONV;
          tmr_start = 1'b1;
          tmr_load  = 32'(SPS_CONV_CYC);
        end
        tsmf_pkg::ST_SHUT: begin
          nxt_state = tsmf_pkg::ST_SHUT;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= tsmf_pkg::ST_CONV;
      boot_ff  <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      boot_ff  <= 1'b0;
    end
  end

  // register file, fault queue, result and alarms
  always_comb begin
    nxt_cfg              = cfg_ff;
    nxt_critical_limit   = critical_limit_ff;
    nxt_hysteresis_value = hysteresis_value_ff;
    nxt_upper_limit      = upper_limit_ff;
    nxt_lower_limit      = lower_limit_ff;
    nxt_temp             = temp_ff;
    nxt_fcnt             = fcnt_ff;
    nxt_crit_al          = crit_al_ff;
    nxt_lim_al           = lim_al_ff;
    if (reg_wr) begin
      unique case (reg_addr)
        tsmf_pkg::ADDR_CFG:  nxt_cfg = reg_wdata[7:0];
        tsmf_pkg::ADDR_CRIT: nxt_critical_limit = reg_wdata;
        tsmf_pkg::ADDR_HYST: nxt_hysteresis_value = reg_wdata[7:0];
        tsmf_pkg::ADDR_HIGH: nxt_upper_limit = reg_wdata;
        tsmf_pkg::ADDR_LOW:  nxt_lower_limit = reg_wdata;
        default: nxt_cfg = cfg_ff;                               // read-only or unmapped
      endcase
    end
    // comparator one-shot: a mode write releases alarms back within hysteresis
    if (mode_wr && !irq_mode && (op == tsmf_pkg::OP_ONESHOT)) begin
      if (below_crit) begin
        nxt_crit_al = 1'b0;
      end
      if (within_lim) begin
        nxt_lim_al = 1'b0;
      end
    end
    // interrupt mode: any register read releases both alarms
    if (irq_mode && reg_rd) begin
      nxt_crit_al = 1'b0;
      nxt_lim_al  = 1'b0;
    end
    if (conv_done) begin
      nxt_temp = adc_sync_ff;
      nxt_fcnt = !fault ? 3'h0 :
                 (fcnt_ff == tsmf_pkg::FCNT_MAX) ? fcnt_ff : 3'(fcnt_ff + 3'h1);
      if (!irq_mode) begin
        if (!crit_hit && below_crit) nxt_crit_al = 1'b0;
        if (!(high_hit || low_hit) && within_lim) nxt_lim_al = 1'b0;
      end
      // a qualified event wins over any clear in the same cycle
      if (qualified && crit_hit) nxt_crit_al = 1'b1;
      if (qualified && (high_hit || low_hit)) nxt_lim_al = 1'b1;
    end
  end

  // status flags: hardware set beats the read or hysteresis clear
  always_comb begin
    logic stat_rd;
    stat_rd       = reg_rd && (reg_addr == tsmf_pkg::ADDR_STATUS);
    nxt_flag_crit = flag_crit_ff && !stat_rd && !(conv_done && below_crit);
    nxt_flag_high = flag_high_ff && !stat_rd && !(conv_done && (t_s < (high_s - hy_s)));
    nxt_flag_low  = flag_low_ff && !stat_rd && !(conv_done && (t_s > (low_s + hy_s)));
    if (conv_done && crit_hit) nxt_flag_crit = 1'b1;
    if (conv_done && high_hit) nxt_flag_high = 1'b1;
    if (conv_done && low_hit) nxt_flag_low = 1'b1;
    nxt_rdy_n = rdy_n_ff;
    if ((reg_rd && (reg_addr == tsmf_pkg::ADDR_TEMP)) ||
        (mode_wr && ((op == tsmf_pkg::OP_ONESHOT) || (op == tsmf_pkg::OP_SPS)))) begin
      nxt_rdy_n = 1'b1;
    end
    if (conv_done) nxt_rdy_n = 1'b0;
  end

  // read data, valid the cycle after the strobe
  always_comb begin
    nxt_rdata = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        tsmf_pkg::ADDR_STATUS: nxt_rdata = {8'h00, rdy_n_ff, flag_crit_ff, flag_high_ff,
                                            flag_low_ff, 4'h0};
        tsmf_pkg::ADDR_CFG:    nxt_rdata = {8'h00, cfg_ff};
        tsmf_pkg::ADDR_TEMP:   nxt_rdata = cfg_ff[tsmf_pkg::CFG_RES16] ? temp_ff :
                                 {temp_ff[15:3], flag_crit_ff, flag_high_ff, flag_low_ff};
        tsmf_pkg::ADDR_ID:     nxt_rdata = {8'h00, ID_VALUE};
        tsmf_pkg::ADDR_CRIT:   nxt_rdata = critical_limit_ff;
        tsmf_pkg::ADDR_HYST:   nxt_rdata = {8'h00, hysteresis_value_ff};
        tsmf_pkg::ADDR_HIGH:   nxt_rdata = upper_limit_ff;
        tsmf_pkg::ADDR_LOW:    nxt_rdata = lower_limit_ff;
        default:               nxt_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_ff              <= tsmf_pkg::CFG_RST;
      critical_limit_ff   <= tsmf_pkg::CRIT_RST;
      hysteresis_value_ff <= tsmf_pkg::HYST_RST;
      upper_limit_ff      <= tsmf_pkg::HIGH_RST;
      lower_limit_ff      <= tsmf_pkg::LOW_RST;
      temp_ff             <= tsmf_pkg::TEMP_RST;
      fcnt_ff             <= 3'h0;
      crit_al_ff          <= 1'b0;
      lim_al_ff           <= 1'b0;
      flag_crit_ff        <= 1'b0;
      flag_high_ff        <= 1'b0;
      flag_low_ff         <= 1'b0;
      rdy_n_ff            <= 1'b1;
      rdata_ff            <= 16'h0000;
    end else begin
      cfg_ff              <= nxt_cfg;
      critical_limit_ff   <= nxt_critical_limit;
      hysteresis_value_ff <= nxt_hysteresis_value;
      upper_limit_ff      <= nxt_upper_limit;
      lower_limit_ff      <= nxt_lower_limit;
      temp_ff             <= nxt_temp;
      fcnt_ff             <= nxt_fcnt;
      crit_al_ff          <= nxt_crit_al;
      lim_al_ff           <= nxt_lim_al;
      flag_crit_ff        <= nxt_flag_crit;
      flag_high_ff        <= nxt_flag_high;
      flag_low_ff         <= nxt_flag_low;
      rdy_n_ff            <= nxt_rdy_n;
      rdata_ff            <= nxt_rdata;
    end
  end

  // open-drain pins pull low for a raised alarm when the programmed active level is low, or for a quiet one when it is high
  assign reg_rdata             = rdata_ff;
  assign critical_alarm_out    = 1'b0;
  assign limit_alarm_out       = 1'b0;
  assign critical_alarm_out_oe = crit_al_ff ^ cfg_ff[tsmf_pkg::CFG_CRIT_POL];
  assign limit_alarm_out_oe    = lim_al_ff ^ cfg_ff[tsmf_pkg::CFG_LIM_POL];

  // checks
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_oneshot_shuts: assert property (conv_done && op == tsmf_pkg::OP_ONESHOT
    |=> state_ff == tsmf_pkg::ST_SHUT [*3]) else $error("one-shot did not shut down");
  a_oneshot_enter: assert property (mode_wr && new_op == tsmf_pkg::OP_ONESHOT
    && state_ff != tsmf_pkg::ST_SHUT |=> state_ff == tsmf_pkg::ST_CONV && tmr_busy)
    else $error("one-shot write did not start a conversion");
  a_irq_read_clr: assert property (irq_mode && reg_rd && !conv_done
    |=> !crit_al_ff && !lim_al_ff) else $error("read did not release alarms");
  a_cmp_lim_clr: assert property (mode_wr && !irq_mode && op == tsmf_pkg::OP_ONESHOT
    && within_lim && !conv_done |=> !lim_al_ff) else $error("limit alarm not released");
  a_cmp_crit_clr: assert property (mode_wr && !irq_mode && op == tsmf_pkg::OP_ONESHOT
    && below_crit && !conv_done |=> !crit_al_ff) else $error("critical alarm not released");
  a_sps_idle: assert property (conv_done && op == tsmf_pkg::OP_SPS
    |=> state_ff == tsmf_pkg::ST_IDLE && tmr_busy) else $error("sps did not idle");
  a_shut_enter: assert property (mode_wr && new_op == tsmf_pkg::OP_SHUT
    |=> state_ff == tsmf_pkg::ST_SHUT) else $error("shutdown not entered");
  a_wake_path: assert property (state_ff == tsmf_pkg::ST_SHUT && mode_wr
    && new_op != tsmf_pkg::OP_SHUT |=> state_ff == tsmf_pkg::ST_WAKE && tmr_busy)
    else $error("shutdown exit did not wake");
  a_shut_holds: assert property (state_ff == tsmf_pkg::ST_SHUT |=> $stable(temp_ff))
    else $error("result changed in shutdown");
  a_fault_reset: assert property (conv_done && !fault |=> fcnt_ff == 3'h0)
    else $error("fault counter not cleared");
  a_alarm_queue: assert property ($rose(crit_al_ff) |-> $past(qualified) && $past(conv_done))
    else $error("alarm rose without full fault queue");
  a_fmt_13bit: assert property (reg_rd && reg_addr == tsmf_pkg::ADDR_TEMP
    && !cfg_ff[tsmf_pkg::CFG_RES16] |=> reg_rdata[15:3] == $past(temp_ff[15:3])
    && reg_rdata[2] == $past(flag_crit_ff)) else $error("13-bit format wrong");

  c_oneshot: cover property (conv_done && op == tsmf_pkg::OP_ONESHOT);
  c_sps_idle: cover property (state_ff == tsmf_pkg::ST_IDLE);
  c_crit_alarm: cover property ($rose(crit_al_ff));
  c_wake: cover property (state_ff == tsmf_pkg::ST_WAKE ##1 state_ff == tsmf_pkg::ST_CONV);
endmodule

// file: tsmf_sensor_model.sv
// front-end model that presents converter words from its own clock domain
`timescale 1ns/10ps
module tsmf_sensor_model (
  input  wire logic        link_clk,
  input  wire logic [15:0] target,
  output logic      [15:0] adc_code
);
  // the word only moves on the front end's clock, never in step with the core
  logic [15:0] word_ff = 16'h0000;
  always @(posedge link_clk) begin
    word_ff <= target;
  end
  assign adc_code = word_ff;
endmodule

// file: tsmf_top_bench.sv
// self-checking bench for the mode sequencer, fault queue and result format
`timescale 1ns/10ps
module tsmf_top_bench;
  localparam int CV = 20;
  localparam int SC = 10;
  localparam int SI = 30;
  localparam int WK = 5;
  logic        core_clk  = 1'b0;
  logic        reset_n   = 1'b0;
  logic        link_clk  = 1'b0;
  logic [15:0] target    = 16'h0c80;
  logic [15:0] adc_code;
  logic [7:0]  reg_addr  = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [15:0] reg_rdata;
  logic        crit_oe;
  logic        lim_oe;
  logic        crit_o;
  logic        lim_o;
  logic        crit_pin;
  logic        lim_pin;
  logic [15:0] last_rd   = 16'h0000;
  logic        rd_d      = 1'b0;
  logic [31:0] seed      = 32'h83b5;
  logic [15:0] exp_q[$];
  int          n_mismatch = 0;
  int          tests_run  = 0;
  int          t;
  logic [15:0] v;

  // core clock and unrelated front-end clock
  always #5 core_clk = ~core_clk;
  always #62.5 link_clk = ~link_clk;

  // pull-ups hold a released alarm pin high
  assign crit_pin = crit_oe ? crit_o : 1'b1;
  assign lim_pin  = lim_oe ? lim_o : 1'b1;

  tsmf_top #(
    .CONV_CYC     (CV),
    .SPS_CONV_CYC (SC),
    .SPS_IDLE_CYC (SI),
    .WAKE_CYC     (WK),
    .ID_VALUE     (8'h3c)  // arbitrary identity value
  ) i_dut (
    .core_clk              (core_clk),
    .reset_n               (reset_n),
    .adc_code              (adc_code),
    .reg_addr              (reg_addr),
    .reg_wdata             (reg_wdata),
    .reg_wr                (reg_wr),
    .reg_rd                (reg_rd),
    .reg_rdata             (reg_rdata),
    .critical_alarm_out    (crit_o),
    .critical_alarm_out_oe (crit_oe),
    .limit_alarm_out       (lim_o),
    .limit_alarm_out_oe    (lim_oe)
  );

  tsmf_sensor_model i_front (
    .link_clk (link_clk),
    .target   (target),
    .adc_code (adc_code)
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] r;
    r = s ^ (s << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction

  // host conversion of a result word to whole degrees
  function automatic int deg_of(input logic [15:0] w, input logic res16);
    int code;
    if (res16) begin
      code = int'(w);
      return w[15] ? (code - 65536) / 128 : code / 128;
    end
    code = int'(w[15:3]);
    return w[15] ? (code - 8192) / 16 : code / 16;
  endfunction

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // one-cycle read strobe; the whole word is one access
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    exp_q.push_back(e);
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask

  task automatic set_t(input logic [15:0] x);
    @(posedge core_clk);
    target <= x;
    repeat (16) @(posedge core_clk);
  endtask

  // one-shot style mode write, then the host waits out a conversion
  task automatic shot(input logic [15:0] x, input logic [15:0] c);
    set_t(x);
    wr(tsmf_pkg::ADDR_CFG, c);
    repeat (WK + CV + 6) @(posedge core_clk);  // a rewrite from shutdown wakes first
  endtask

  // read data is valid only in the cycle after the strobe
  always @(posedge core_clk) begin
    rd_d <= reg_rd;
  end
  always @(negedge core_clk) begin
    if (rd_d) begin
      last_rd = reg_rdata;
      if (exp_q.size() == 0) check("read queue", 16'h0001, 16'h0000);
      else check("read data", reg_rdata, exp_q.pop_front());
    end
  end

  initial begin
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    // reset values, read before the first conversion lands
    rd(tsmf_pkg::ADDR_TEMP, 16'h0000);
    rd(tsmf_pkg::ADDR_STATUS, 16'h0080);
    rd(tsmf_pkg::ADDR_CFG, 16'h0000);
    rd(tsmf_pkg::ADDR_CRIT, 16'h4980);
    rd(tsmf_pkg::ADDR_HYST, 16'h0005);
    rd(tsmf_pkg::ADDR_HIGH, 16'h2000);
    rd(tsmf_pkg::ADDR_LOW, 16'h0500);
    rd(8'h1f, 16'h0000);
    // continuous conversions of random in-limit words
    for (t = 0; t < 3; t++) begin
      seed = xs(seed);
      v = 16'h0600 + {4'h0, seed[11:0]};
      set_t(v);
      repeat (2 * CV + 8) @(posedge core_clk);
      rd(tsmf_pkg::ADDR_TEMP, {v[15:3], 3'b000});
    end
    wr(tsmf_pkg::ADDR_TEMP, 16'hffff);
    rd(tsmf_pkg::ADDR_TEMP, {v[15:3], 3'b000});
    wr(tsmf_pkg::ADDR_CFG, 16'h0080);
    repeat (CV + 4) @(posedge core_clk);
    rd(tsmf_pkg::ADDR_TEMP, v);
    // a negative reading converted the way a host would, in both widths
    set_t(16'hec00);
    repeat (2 * CV + 8) @(posedge core_clk);
    rd(tsmf_pkg::ADDR_TEMP, 16'hec00);
    @(posedge core_clk);
    check("degrees 16-bit", 16'(deg_of(last_rd, 1'b1)), 16'hffd8);
    wr(tsmf_pkg::ADDR_CFG, 16'h0000);
    repeat (CV + 4) @(posedge core_clk);
    rd(tsmf_pkg::ADDR_TEMP, 16'hec01);
    @(posedge core_clk);
    check("degrees 13-bit", 16'(deg_of(last_rd, 1'b0)), 16'hffd8);
    $display("test continuous done");
    // one-shot converts once, then holds
    shot(16'h0c88, 16'h0020);
    rd(tsmf_pkg::ADDR_TEMP, 16'h0c88);
    set_t(16'h1000);
    repeat (2 * CV + 8) @(posedge core_clk);
    rd(tsmf_pkg::ADDR_TEMP, 16'h0c88);
    shot(16'h1000, 16'h0020);
    rd(tsmf_pkg::ADDR_TEMP, 16'h1000);
    $display("test one-shot done");
    // shutdown keeps the result, leaving it wakes and converts
    set_t(16'h0d00);
    wr(tsmf_pkg::ADDR_CFG, 16'h0060);
    repeat (2 * CV + 8) @(posedge core_clk);
    rd(tsmf_pkg::ADDR_TEMP, 16'h1000);
    wr(tsmf_pkg::ADDR_CFG, 16'h0000);
    repeat (WK + CV + 6) @(posedge core_clk);
    rd(tsmf_pkg::ADDR_TEMP, 16'h0d00);
    $display("test shutdown done");
    // one sample per period: short convert, long idle
    set_t(16'h0e00);
    wr(tsmf_pkg::ADDR_CFG, 16'h0040);
    repeat (SC + 4) @(posedge core_clk);
    rd(tsmf_pkg::ADDR_TEMP, 16'h0e00);
    set_t(16'h0f00);
    rd(tsmf_pkg::ADDR_TEMP, 16'h0e00);
    repeat (SI) @(posedge core_clk);
    rd(tsmf_pkg::ADDR_TEMP, 16'h0f00);
    $display("test one-per-period done");
    // fault queue depth one to four, broken run resets the count
    for (t = 0; t < 4; t++) begin
      shot(16'h0c80, {14'h0008, t[1:0]});
      for (int k = 0; k < t; k++) begin
        shot(16'h2800, {14'h0008, t[1:0]});
        check("limit pin", {15'h0, lim_oe}, 16'h0000);
      end
      shot(16'h0c80, {14'h0008, t[1:0]});
      for (int k = 0; k <= t; k++) begin
        shot(16'h2800, {14'h0008, t[1:0]});
        check("limit pin", {15'h0, lim_oe}, {15'h0, k == t});
        check("critical pin", {15'h0, crit_oe}, 16'h0000);
      end
    end
    $display("test fault queue done");
    // critical and low crossings with flags in the low bits
    shot(16'h5000, 16'h0020);
    check("critical pin", {15'h0, crit_oe}, 16'h0001);
    check("limit pin", {15'h0, lim_oe}, 16'h0001);
    check("pin levels", {14'h0, crit_pin, lim_pin}, 16'h0000);
    rd(tsmf_pkg::ADDR_TEMP, 16'h5006);
    shot(16'h0000, 16'h0020);
    check("critical pin", {15'h0, crit_oe}, 16'h0000);
    check("limit pin", {15'h0, lim_oe}, 16'h0001);
    rd(tsmf_pkg::ADDR_TEMP, 16'h0001);
    $display("test limits done");
    // interrupt mode: any read drops both pins
    shot(16'h0c80, 16'h0020);
    check("limit pin", {15'h0, lim_oe}, 16'h0000);
    shot(16'h5000, 16'h0030);
    check("critical pin", {15'h0, crit_oe}, 16'h0001);
    rd(tsmf_pkg::ADDR_ID, 16'h003c);
    repeat (2) @(posedge core_clk);
    check("critical pin", {15'h0, crit_oe}, 16'h0000);
    check("limit pin", {15'h0, lim_oe}, 16'h0000);
    $display("test interrupt done");
    repeat (4) @(posedge core_clk);
    close_out();
  end

  // hang guard
  initial begin
    repeat (60000) @(posedge core_clk);
    n_mismatch++;
    close_out();
  end
endmodule
